// [fmac_pkg.sv]
`default_nettype none
package fmac_pkg;
    // Register byte offsets on the AHB-Lite slave.
    localparam logic [7:0]  OFF_CONFIG_ONE   = 8'h00;
    localparam logic [7:0]  OFF_PROTECTION   = 8'h04;
    localparam logic [7:0]  OFF_IMAGE_LOW    = 8'h08;
    localparam logic [7:0]  OFF_STATUS       = 8'h0C;
    localparam logic [7:0]  OFF_CONFIG_ZERO  = 8'h10;
    // Field positions in flash_config_one.
    localparam int          POL_LSB          = 0;
    localparam int          POL_MSB          = 2;
    localparam int          HOLD_EN_BIT      = 3;
    // Field positions in flash_config_zero.
    localparam int          DPFE_BIT         = 0;
    localparam int          IPFE_BIT         = 1;
    localparam int          BFE_BIT          = 2;
    // Field positions in master_access_protection.
    localparam int          PERM_LSB         = 0;
    localparam int          PERM_MSB         = 1;
    localparam int          VETO_BIT         = 16;
    // Policy encodings.
    localparam logic [2:0]  POL_STALL_QUIET  = 3'h7;
    localparam logic [2:0]  POL_STALL_NOTIFY = 3'h6;
    localparam logic [2:0]  POL_ABORT_QUIET  = 3'h5;
    localparam logic [2:0]  POL_ABORT_NOTIFY = 3'h4;
    // Reset values.
    localparam logic [31:0] RST_CONFIG_ONE   = 32'h0000000F;
    localparam logic [31:0] RST_CONFIG_ZERO  = 32'h00000007;
    localparam logic [31:0] RST_PROTECTION   = 32'hFFFFFFFF;
    // Shadow location of the protection image.
    localparam logic [23:0] SHADOW_ADDR      = 24'h203E00;
    // Master number of the core.
    localparam logic [3:0]  MASTER0_ID       = 4'h0;
    // AHB encodings.
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
    localparam logic [2:0]  HSIZE_WORD       = 3'h2;
endpackage
`default_nettype wire

// [fmac_top.sv]
// Decided for this implementation: the AHB-Lite register port and the address map.
`default_nettype none
module fmac_top (
    // Clock and reset.
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_resetn,
    // AHB-Lite register slave.
    input  wire logic                 i_hsel,
    input  wire logic [31:0]          i_haddr,
    input  wire logic [1:0]           i_htrans,
    input  wire logic                 i_hwrite,
    input  wire logic [2:0]           i_hsize,
    input  wire logic [31:0]          i_hwdata,
    input  wire logic                 i_hready,
    output logic                      o_hreadyout,
    output logic                      o_hresp,
    output logic [31:0]               o_hrdata,
    // Flash access requests from bus masters.
    input  wire logic                 i_req_valid,
    input  wire logic                 i_req_write,
    input  wire logic [3:0]           i_req_master,
    input  wire logic                 i_req_instr,
    input  wire logic [31:0]          i_req_addr,
    input  wire logic [31:0]          i_req_wdata,
    output logic                      o_req_done,
    output logic                      o_req_error,
    output logic [31:0]               o_req_rdata,
    output logic                      o_prefetch_allow,
    // Bank1 array.
    input  wire logic                 i_single_bank,
    input  wire logic                 i_arr_busy,
    input  wire logic                 i_arr_done,
    input  wire logic                 i_arr_error,
    input  wire logic [127:0]         i_arr_rdata,
    output logic                      o_arr_start,
    output logic                      o_arr_write,
    output logic [31:0]               o_arr_addr,
    output logic [31:0]               o_arr_wdata,
    output logic                      o_arr_abort,
    output logic                      o_stall_notify,
    output logic                      o_abort_notify,
    // Shadow word fetch during the reset phase.
    input  wire logic                 i_shadow_valid,
    input  wire logic [63:0]          i_shadow_word,
    output logic                      o_shadow_req,
    output logic [23:0]               o_shadow_addr
);
    import fmac_pkg::*;

    typedef enum logic [5:0] {
        ST_BOOT_REQ  = 6'h01,
        ST_BOOT_WAIT = 6'h02,
        ST_IDLE      = 6'h04,
        ST_STALL     = 6'h08,
        ST_ARRAY     = 6'h10,
        ST_DONE      = 6'h20
    } fmac_state_type;

    fmac_state_type st_q;
    logic [31:0]    cfg1_q;
    logic [31:0]    cfg0_q;
    logic [31:0]    prot_q;
    logic [31:0]    image_q;
    logic           loaded_q;
    logic [127:0]   line_q;
    logic [27:0]    tag_q;
    logic           hold_valid_q;
    logic           req_wr_q;
    logic [3:2]     word_q;
    logic           dph_wr_q;
    logic [7:0]     dph_addr_q;
    logic [2:0]     pol;
    logic           hold_en;
    logic           is_m0;
    logic [1:0]     perm;
    logic           take;
    logic           denied;
    logic           busy_rd;
    logic           hit;
    logic           aph;
    logic [31:0]    rd_mux;

    assign pol     = cfg1_q[POL_MSB:POL_LSB];
    assign hold_en = cfg1_q[HOLD_EN_BIT];
    assign is_m0   = (i_req_master == MASTER0_ID);
    assign perm    = is_m0 ? prot_q[PERM_MSB:PERM_LSB] : 2'h3;
    assign take    = (st_q == ST_IDLE) && i_req_valid;
    assign denied  = i_req_write ? !perm[1] : !perm[0];
    assign busy_rd = !i_req_write && i_arr_busy;
    // A disabled holding register never hits, whatever it still holds.
    assign hit     = hold_en && hold_valid_q && !i_req_write && (i_req_addr[31:4] == tag_q);

    // AHB-Lite slave: zero wait states, always OKAY.
    assign aph         = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ) && (i_hsize == HSIZE_WORD);
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;

    always_comb begin
        rd_mux = 32'h00000000;
        case (i_haddr[7:0])
            OFF_CONFIG_ONE:  rd_mux = cfg1_q;
            OFF_PROTECTION:  rd_mux = prot_q;
            OFF_IMAGE_LOW:   rd_mux = image_q;
            OFF_STATUS:      rd_mux = {26'h0000000, st_q == ST_STALL, i_arr_busy, hold_valid_q,
                                       hold_en, i_single_bank, loaded_q};
            OFF_CONFIG_ZERO: rd_mux = cfg0_q;
            default:         rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            dph_wr_q   <= 1'b0;
            dph_addr_q <= 8'h00;
            o_hrdata   <= 32'h00000000;
        end else begin
            dph_wr_q   <= aph && i_hwrite;
            dph_addr_q <= i_haddr[7:0];
            if (aph && !i_hwrite) begin
                o_hrdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            cfg1_q <= RST_CONFIG_ONE;
            cfg0_q <= RST_CONFIG_ZERO;
        end else if (dph_wr_q) begin
            if (dph_addr_q == OFF_CONFIG_ONE) begin
                cfg1_q <= {28'h0000000, i_hwdata[HOLD_EN_BIT:0]};
            end
            if (dph_addr_q == OFF_CONFIG_ZERO) begin
                cfg0_q <= {29'h00000000, i_hwdata[BFE_BIT:0]};
            end
        end
    end

    // A software write only changes the live copy; the next reset reloads the shadow word.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            prot_q   <= RST_PROTECTION;
            image_q  <= RST_PROTECTION;
            loaded_q <= 1'b0;
        end else if ((st_q == ST_BOOT_WAIT) && i_shadow_valid) begin
            prot_q   <= i_shadow_word[31:0];
            image_q  <= i_shadow_word[31:0];
            loaded_q <= 1'b1;
        end else if (dph_wr_q && (dph_addr_q == OFF_PROTECTION)) begin
            prot_q <= i_hwdata;
        end
    end

    // Access sequencer; requests wait until the protection image is in.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            st_q <= ST_BOOT_REQ;
        end else begin
            case (st_q)
                ST_BOOT_REQ:  st_q <= ST_BOOT_WAIT;
                ST_BOOT_WAIT: if (i_shadow_valid) begin
                    st_q <= ST_IDLE;
                end
                ST_IDLE: if (take) begin
                    if (denied) begin
                        st_q <= ST_DONE;
                    end else if (busy_rd && !i_single_bank && !pol[2]) begin
                        st_q <= ST_DONE;
                    end else if (busy_rd) begin
                        st_q <= ST_STALL;
                    end else if (hit) begin
                        st_q <= ST_DONE;
                    end else begin
                        st_q <= ST_ARRAY;
                    end
                end
                ST_STALL: if (!i_arr_busy) begin
                    st_q <= ST_ARRAY;
                end
                ST_ARRAY: if (i_arr_done) begin
                    st_q <= ST_DONE;
                end
                ST_DONE:  st_q <= ST_IDLE;
                default:  st_q <= ST_BOOT_REQ;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_shadow_req  <= 1'b0;
            o_shadow_addr <= SHADOW_ADDR;
        end else begin
            o_shadow_req  <= (st_q == ST_BOOT_REQ);
            o_shadow_addr <= SHADOW_ADDR;
        end
    end

    // Policy side effects are one-cycle pulses at stall entry; single bank suppresses them.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_stall_notify <= 1'b0;
            o_arr_abort    <= 1'b0;
            o_abort_notify <= 1'b0;
        end else begin
            o_stall_notify <= 1'b0;
            o_arr_abort    <= 1'b0;
            o_abort_notify <= 1'b0;
            if (take && !denied && busy_rd && !i_single_bank) begin
                o_stall_notify <= (pol == POL_STALL_NOTIFY);
                o_arr_abort    <= (pol == POL_ABORT_QUIET) || (pol == POL_ABORT_NOTIFY);
                o_abort_notify <= (pol == POL_ABORT_NOTIFY);
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_arr_start <= 1'b0;
            o_arr_write <= 1'b0;
            o_arr_addr  <= 32'h00000000;
            o_arr_wdata <= 32'h00000000;
            req_wr_q    <= 1'b0;
            word_q      <= 2'h0;
        end else begin
            o_arr_start <= (take && !denied && !busy_rd && !hit) || ((st_q == ST_STALL) && !i_arr_busy);
            if (take) begin
                o_arr_write <= i_req_write;
                o_arr_addr  <= i_req_addr;
                o_arr_wdata <= i_req_wdata;
                req_wr_q    <= i_req_write;
                word_q      <= i_req_addr[3:2];
            end
        end
    end

    // Completion status and data.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_req_error <= 1'b0;
            o_req_rdata <= 32'h00000000;
        end else if (take) begin
            o_req_error <= denied || (busy_rd && !i_single_bank && !pol[2]);
            if (hit && !denied && !busy_rd) begin
                o_req_rdata <= line_q[32*i_req_addr[3:2] +: 32];
            end
        end else if ((st_q == ST_ARRAY) && i_arr_done) begin
            o_req_error <= i_arr_error;
            if (!req_wr_q) begin
                o_req_rdata <= i_arr_rdata[32*word_q +: 32];
            end
        end
    end

    assign o_req_done = (st_q == ST_DONE);

    // Holding register; an errored read does not fill it, a write that reaches the array drops it.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            line_q       <= 128'h0;
            tag_q        <= 28'h0000000;
            hold_valid_q <= 1'b0;
        end else if (!hold_en) begin
            hold_valid_q <= 1'b0;
        end else if ((st_q == ST_ARRAY) && i_arr_done) begin
            hold_valid_q <= !req_wr_q && !i_arr_error;
            if (!req_wr_q && !i_arr_error) begin
                line_q <= i_arr_rdata;
                tag_q  <= o_arr_addr[31:4];
            end
        end
    end

    // Prefetch permission for the request just taken.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_prefetch_allow <= 1'b0;
        end else if (take) begin
            o_prefetch_allow <= !(is_m0 && prot_q[VETO_BIT]) && cfg0_q[BFE_BIT]
                                && (i_req_instr ? cfg0_q[IPFE_BIT] : cfg0_q[DPFE_BIT]);
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    a_err_policy_low: assert property (take && !denied && busy_rd && !i_single_bank && !pol[2]
        |=> o_req_done && o_req_error && !o_arr_start) else $error("busy read not errored");
    a_stall_quiet: assert property (take && !denied && busy_rd && !i_single_bank && pol == 3'h7
        |=> st_q == ST_STALL && !o_stall_notify && !o_arr_abort && !o_abort_notify)
        else $error("quiet stall wrong");
    a_stall_notify: assert property (take && !denied && busy_rd && !i_single_bank && pol == 3'h6
        |=> o_stall_notify && !o_arr_abort) else $error("stall notify missing");
    a_abort_quiet: assert property (take && !denied && busy_rd && !i_single_bank && pol == 3'h5
        |=> o_arr_abort && !o_abort_notify && !o_stall_notify) else $error("quiet abort wrong");
    a_abort_notify: assert property (take && !denied && busy_rd && !i_single_bank && pol == 3'h4
        |=> o_arr_abort && o_abort_notify) else $error("abort notify missing");
    a_reset_fields: assert property (st_q == ST_BOOT_REQ |-> pol == 3'h7 && hold_en)
        else $error("reset field values wrong");
    a_single_ignore: assert property (take && !denied && busy_rd && i_single_bank
        |=> st_q == ST_STALL && !o_req_error && !o_arr_abort && !o_stall_notify)
        else $error("single bank used policy");
    a_hold_off: assert property (take && !denied && !busy_rd && !hold_en |=> o_arr_start)
        else $error("disabled holding register served");
    a_hold_inval: assert property (!hold_en |=> !hold_valid_q) else $error("holding not invalidated");
    a_boot_load: assert property (st_q == ST_BOOT_WAIT && i_shadow_valid
        |=> prot_q == $past(i_shadow_word[31:0]) && st_q == ST_IDLE) else $error("shadow not loaded");
    a_refuse: assert property (take && denied |=> o_req_done && o_req_error && !o_arr_start)
        else $error("refused access not errored");
    a_hit_fast: assert property (take && !denied && !busy_rd && hit |=> o_req_done && !o_req_error && !o_arr_start)
        else $error("hit not zero wait");
    a_stall_resume: assert property (st_q == ST_STALL && !i_arr_busy |=> o_arr_start && st_q == ST_ARRAY)
        else $error("stalled read not resumed");
    a_veto_block: assert property (take && is_m0 && prot_q[VETO_BIT] |=> !o_prefetch_allow)
        else $error("vetoed prefetch allowed");

    c_stall_resume: cover property (st_q == ST_STALL ##[1:50] st_q == ST_DONE);
    c_abort: cover property (o_arr_abort && o_abort_notify);
    c_hit: cover property (take && hit);
    c_refuse: cover property (take && denied);
endmodule
`default_nettype wire

// [fmac_array_model.sv]
`default_nettype none
module fmac_array_model (
    // Clock and reset.
    input  wire logic          i_clk_sys,
    input  wire logic          i_resetn,
    // Controller side.
    input  wire logic          i_start,
    input  wire logic          i_abort,
    input  wire logic          i_shadow_req,
    input  wire logic          i_busy_cmd,
    // Array answers.
    output logic               o_busy,
    output logic               o_done,
    output logic [127:0]       o_rdata,
    output logic               o_shadow_valid,
    output logic [63:0]        o_shadow_word
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [127:0] LINE   = 128'h44444444333333332222222211111111;
    localparam logic [63:0]  SHADOW = 64'hA5A5A5A500000003;
    logic       aborted_q;
    logic [2:0] wait_q;
    assign o_busy = i_busy_cmd & ~aborted_q;
    // An abort ends the operation, so busy falls until the bench starts another.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) aborted_q <= 1'b0;
        else if (!i_busy_cmd) aborted_q <= 1'b0;
        else if (i_abort) aborted_q <= 1'b1;
    end
    // The line stands only with done; otherwise it toggles so stale data never looks valid.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            wait_q <= 3'h0;
            o_done <= 1'b0;
            o_rdata <= ~LINE;
        end else begin
            o_done <= (wait_q == 3'h1);
            o_rdata <= (wait_q == 3'h1) ? LINE : ~o_rdata;
            if (i_start) wait_q <= 3'h4;
            else if (wait_q != 3'h0) wait_q <= wait_q - 3'h1;
        end
    end
    // The upper half holds check bits that must not reach the register.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) o_shadow_word <= 64'h0;
        else o_shadow_word <= i_shadow_req ? SHADOW : ~o_shadow_word;
    end
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) o_shadow_valid <= 1'b0;
        else o_shadow_valid <= i_shadow_req;
    end
endmodule
`default_nettype wire

// [test_flash_master_access_control.sv]
`default_nettype none
module test_flash_master_access_control;
    timeunit 1ns;
    timeprecision 1ps;
    import fmac_pkg::*;
    logic clk, rstn, hwrite, rq_valid, rq_write, sbank, busy_cmd, hrdy, done, rerr, pf, astart, aabort;
    logic snote, anote, shreq, arr_busy, arr_done, sh_valid, rq_instr;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    logic [3:0]   rq_master;
    logic [23:0]  shaddr;
    logic [31:0]  haddr, hwdata, hrdata, rq_addr, rdata, d;
    logic [63:0]  sh_word;
    logic [127:0] arr_rdata;
    logic         err;
    int           miscompares, checks_done, starts, stalls, aborts, anotes, cyc;
    fmac_top i_dut (.i_clk_sys(clk), .i_resetn(rstn), .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy),
        .o_hresp(), .o_hrdata(hrdata), .i_req_valid(rq_valid), .i_req_write(rq_write),
        .i_req_master(rq_master), .i_req_instr(rq_instr), .i_req_addr(rq_addr), .i_req_wdata(32'h5A5A5A5A),
        .o_req_done(done), .o_req_error(rerr), .o_req_rdata(rdata), .o_prefetch_allow(pf),
        .i_single_bank(sbank), .i_arr_busy(arr_busy), .i_arr_done(arr_done), .i_arr_error(1'b0),
        .i_arr_rdata(arr_rdata), .o_arr_start(astart), .o_arr_write(), .o_arr_addr(), .o_arr_wdata(),
        .o_arr_abort(aabort), .o_stall_notify(snote), .o_abort_notify(anote), .i_shadow_valid(sh_valid),
        .i_shadow_word(sh_word), .o_shadow_req(shreq), .o_shadow_addr(shaddr));
    fmac_array_model i_array (.i_clk_sys(clk), .i_resetn(rstn), .i_start(astart), .i_abort(aabort),
        .i_shadow_req(shreq), .i_busy_cmd(busy_cmd), .o_busy(arr_busy), .o_done(arr_done),
        .o_rdata(arr_rdata), .o_shadow_valid(sh_valid), .o_shadow_word(sh_word));
    always @(posedge clk) begin
        starts += int'(astart === 1'b1);
        stalls += int'(snote === 1'b1);
        aborts += int'(aabort === 1'b1);
        anotes += int'(anote === 1'b1);
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        if (miscompares == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        haddr <= {24'h0, addr};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        hsize <= HSIZE_WORD;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask
    // Busy is released after 20 cycles so a stalled read can finish.
    task automatic req(input logic wr, input logic [31:0] addr);
        @(posedge clk);
        rq_valid <= 1'b1;
        rq_write <= wr;
        rq_master <= MASTER0_ID;
        rq_addr <= addr;
        cyc = 0;
        do begin
            @(posedge clk);
            cyc++;
            if (cyc == 20) busy_cmd <= 1'b0;
        end while (done !== 1'b1 && cyc < 200);
        rq_valid <= 1'b0;
        err = rerr;
        d = rdata;
        check("request done", {31'h0, done}, 32'h1);
    endtask
    task automatic do_reset();
        rstn <= 1'b0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
    task automatic t_reset_values();
        check("shadow address", {8'h0, shaddr}, 32'h00203E00);
        ahb(1'b0, OFF_CONFIG_ONE, 32'h0, d);
        check("config one reset", d, 32'h0000000F);
        ahb(1'b0, OFF_PROTECTION, 32'h0, d);
        check("protection from shadow", d, 32'h00000003);
        ahb(1'b0, 8'h40, 32'h0, d);
        check("unmapped read", d, 32'h0);
    endtask
    task automatic t_permission();
        int s0;
        ahb(1'b1, OFF_CONFIG_ONE, 32'h7, d);
        for (int p = 0; p < 4; p++) begin
            ahb(1'b1, OFF_PROTECTION, 32'(p), d);
            s0 = starts;
            req(1'b0, 32'h8);
            check("read refused", err, 32'(!p[0]));
            req(1'b1, 32'h8);
            check("write refused", err, 32'(!p[1]));
            check("array starts", 32'(starts - s0), 32'(p[0] + p[1]));
        end
    endtask
    task automatic t_policy();
        int s0, a0, n0;
        for (int p = 0; p < 8; p++) begin
            ahb(1'b1, OFF_CONFIG_ONE, 32'(p), d);
            s0 = stalls;
            a0 = aborts;
            n0 = anotes;
            busy_cmd <= 1'b1;
            req(1'b0, 32'h8);
            busy_cmd <= 1'b0;
            check("busy read error", err, 32'(p < 4));
            if (p >= 4) check("stalled read data", d, 32'h33333333);
            check("stall held", 32'(cyc > 20), 32'(p >= 6));
            check("stall notify", 32'(stalls - s0), 32'(p == 6));
            check("abort", 32'(aborts - a0), 32'(p == 4 || p == 5));
            check("abort notify", 32'(anotes - n0), 32'(p == 4));
        end
        // Policy 000 would error on multi bank, so a clean stall here shows the field is ignored.
        ahb(1'b1, OFF_CONFIG_ONE, 32'h0, d);
        a0 = aborts;
        sbank <= 1'b1;
        busy_cmd <= 1'b1;
        req(1'b0, 32'h8);
        busy_cmd <= 1'b0;
        sbank <= 1'b0;
        check("single bank no error", err, 32'h0);
        check("single bank no abort", 32'(aborts - a0), 32'h0);
    endtask
    task automatic t_holding();
        int s0;
        ahb(1'b1, OFF_CONFIG_ONE, 32'hF, d);
        req(1'b0, 32'h100);
        check("miss data", d, 32'h11111111);
        s0 = starts;
        req(1'b0, 32'h104);
        check("hit data", d, 32'h22222222);
        check("hit no wait", 32'(cyc) + 32'(starts - s0), 32'h2);
        ahb(1'b1, OFF_CONFIG_ONE, 32'h7, d);
        req(1'b0, 32'h104);
        ahb(1'b1, OFF_CONFIG_ONE, 32'hF, d);
        req(1'b0, 32'h104);
        check("disabled and invalidated", 32'(starts - s0), 32'h2);
    endtask
    task automatic t_prefetch();
        ahb(1'b1, OFF_PROTECTION, 32'h00010003, d);
        req(1'b0, 32'h200);
        check("veto set", pf, 32'h0);
        ahb(1'b1, OFF_PROTECTION, 32'h00000003, d);
        req(1'b0, 32'h200);
        check("veto clear", pf, 32'h1);
        ahb(1'b1, OFF_CONFIG_ZERO, 32'h6, d);
        req(1'b0, 32'h200);
        check("data prefetch off", pf, 32'h0);
        rq_instr <= 1'b1;
        req(1'b0, 32'h200);
        check("instr prefetch on", pf, 32'h1);
        ahb(1'b1, OFF_CONFIG_ZERO, 32'h5, d);
        req(1'b0, 32'h200);
        check("instr prefetch off", pf, 32'h0);
        rq_instr <= 1'b0;
        ahb(1'b1, OFF_PROTECTION, 32'h00010001, d);
        do_reset();
        ahb(1'b0, OFF_PROTECTION, 32'h0, d);
        check("write lost at reset", d, 32'h00000003);
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #100000;
        miscompares++;
        results();
    end
    initial begin
        {rstn, hwrite, rq_valid, rq_write, sbank, busy_cmd, htrans, hsize, rq_instr} = '0;
        {rq_master, haddr, hwdata, rq_addr} = '0;
        do_reset();
        t_reset_values();
        t_permission();
        t_policy();
        t_holding();
        t_prefetch();
        results();
    end
endmodule
`default_nettype wire
